// *** rtl/sto_pkg.sv ***
// constants and types shared by the safe torque off monitor
package sto_pkg;
	localparam int unsigned CLK_HZ          = 100_000_000;
	localparam int unsigned STOP_RESP_MS    = 20;
	localparam int unsigned STOP_RESP_CYC   = STOP_RESP_MS * (CLK_HZ / 1000);
	localparam int unsigned RETURN_TIME_S   = 30;
	localparam int unsigned SKEW_LIMIT_CS   = 0;
	localparam int unsigned CYC_PER_CS      = CLK_HZ / 100;
	localparam int unsigned CYC_PER_S       = CLK_HZ;
	localparam int unsigned TIME_W          = 8;
	localparam int unsigned CNT_W           = 32;
	localparam logic [7:0]  OUT11_FEEDBACK  = 8'h3E;
	localparam logic [7:0]  OUT11_NONE      = 8'hFF;
	localparam int unsigned IN3_BIT         = 2;
	localparam int unsigned IN4_BIT         = 3;
	localparam int unsigned INPUT_W         = 8;

	typedef enum logic [2:0] {
		MODE_NONE    = 3'h0,
		MODE_LATCH   = 3'h1,
		MODE_EXT_INT = 3'h2,
		MODE_INT_A   = 3'h3,
		MODE_INT_B   = 3'h4,
		MODE_WARN_I  = 3'h5,
		MODE_WARN    = 3'h6
	} disp_mode_type;

	typedef enum logic [1:0] {
		POL_HOLD   = 2'h0,
		POL_RETURN = 2'h1
	} ret_policy_type;

	typedef enum logic [1:0] {
		VIEW_SAFETY   = 2'h0,
		VIEW_STANDARD = 2'h1
	} view_type;

	typedef enum logic [3:0] {
		CODE_NONE    = 4'h0,
		CODE_STO     = 4'h1,
		CODE_E37     = 4'h2,
		CODE_E98     = 4'h3,
		CODE_E99     = 4'h4,
		CODE_A_LATE_ON  = 4'h5,
		CODE_B_LATE_ON  = 4'h6,
		CODE_A_LATE_OFF = 4'h7,
		CODE_B_LATE_OFF = 4'h8
	} code_type;
endpackage : sto_pkg

// *** rtl/sync_if.sv ***
// synchronised stop inputs passed from the synchroniser to the monitor
interface sync_if;
	logic a;
	logic b;
	logic fb;
	modport src (output a, output b, output fb);
	modport dst (input a, input b, input fb);
endinterface : sync_if

// *** rtl/stop_sync.sv ***
// two-stage synchroniser for the stop inputs and feedback
module stop_sync (
	// clock and reset
	input  wire logic clock_i,
	input  wire logic nrst_i,
	// raw pins
	input  wire logic a_i,
	input  wire logic b_i,
	input  wire logic fb_i,
	// synchronised levels
	sync_if.src       s
);
	// inputs off and feedback at stop: a consistent idle, no false mismatch
	localparam logic [2:0] SYNC_RST = 3'h4;

	logic [2:0] meta_r;
	logic [2:0] sync_r;

	// inactive after reset so the stage starts disabled
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			meta_r <= SYNC_RST;
			sync_r <= SYNC_RST;
		end else begin
			meta_r <= {fb_i, b_i, a_i};
			sync_r <= meta_r;
		end
	end

	assign s.a  = sync_r[0];
	assign s.b  = sync_r[1];
	assign s.fb = sync_r[2];
endmodule : stop_sync

// *** rtl/sto_monitor.sv ***
// safe torque off monitor: power gating, fault codes and safety display
// Notes on behaviour
// - power stage enable drops while either stop input is inactive
// - output stages are off well within 20 ms of a stop input dropping
// - diag selector on forces output 11 to feedback function 62
// - diag selector returning to off leaves output 11 without function
// - diag on: stop inputs shown in input monitor bits of inputs 3, 4
// - held run command restarts once both inputs active and fault cleared
// - mode 00 gives no fault on stop inputs going inactive
// - mode 01 latches stop fault; fault reset or power cycle clears it
// - mode 02 latches external disagree and internal mismatch, power off only
// - modes 03 and 04 latch only internal mismatch, cleared at power off
// - modes 05 and 06 warn on disagreement; cleared with both inactive
// - mode 05 also latches internal mismatch until power off
// - a late switching on warns a-late-on; b late warns b-late-on
// - a late switching off warns a-late-off; b late warns b-late-off
// - on-skew beyond configured limit, default 0 s, shows late-on warnings
// - on-skew limit applies only in display mode 05
// - stop inputs disagreeing with feedback count as internal fault in modes 02 to 05
// - summary output set while any warning or fault is active
// - policy 00: key presses never replace the safety display
// - policy 01: key shows standard view, timer returns to safety view
// - return time is configurable, 30 s by default
module sto_monitor
	import sto_pkg::*;
#(
	parameter int unsigned RESP_CYC  = sto_pkg::STOP_RESP_CYC,
	parameter int unsigned CS_CYC    = sto_pkg::CYC_PER_CS,
	parameter int unsigned SEC_CYC   = sto_pkg::CYC_PER_S
) (
	// clock and reset
	input  wire logic                      clock_i,
	input  wire logic                      nrst_i,
	// safety pins
	input  wire logic                      stop_input_a_i,
	input  wire logic                      stop_input_b_i,
	input  wire logic                      stop_state_feedback_i,
	input  wire logic                      diag_select_switch_i,
	input  wire logic                      fault_reset_input_i,
	// drive control
	input  wire logic                      run_cmd_i,
	input  wire logic                      key_press_i,
	// configuration
	input  wire logic [2:0]                stop_display_mode_i,
	input  wire logic [sto_pkg::TIME_W-1:0] on_skew_limit_i,
	input  wire logic [1:0]                display_return_policy_i,
	input  wire logic [sto_pkg::TIME_W-1:0] safety_display_return_time_i,
	input  wire logic [7:0]                output11_function_i,
	input  wire logic [sto_pkg::INPUT_W-1:0] digital_inputs_i,
	// status
	output logic                           power_enable_o,
	output logic                           motor_run_o,
	output logic                           stop_fault_o,
	output logic                           external_disagree_fault_o,
	output logic                           internal_mismatch_fault_o,
	output logic                           warn_a_late_on_o,
	output logic                           warn_b_late_on_o,
	output logic                           warn_a_late_off_o,
	output logic                           warn_b_late_off_o,
	output logic                           safety_fault_summary_o,
	output logic                           torque_off_ind_o,
	output logic [3:0]                     display_code_o,
	output logic                           standard_view_o,
	output logic [7:0]                     output11_function_o,
	output logic [sto_pkg::INPUT_W-1:0]    input_status_monitor_o
);
	import sto_pkg::*;

	sync_if s ();

	stop_sync u_sync (
		.clock_i (clock_i),
		.nrst_i  (nrst_i),
		.a_i     (stop_input_a_i),
		.b_i     (stop_input_b_i),
		.fb_i    (stop_state_feedback_i),
		.s       (s)
	);

	disp_mode_type mode;
	assign mode = disp_mode_type'(stop_display_mode_i);

	logic a_d_r;
	logic b_d_r;
	logic both_on;
	logic both_off;
	logic disagree;
	logic mismatch;
	logic warn_mode;
	logic fault_any;
	logic warn_any;

	assign both_on   = s.a & s.b;
	assign both_off  = ~s.a & ~s.b;
	assign disagree  = s.a ^ s.b;
	// feedback reports stop active only when both inputs are off
	assign mismatch  = s.fb != both_off;
	assign warn_mode = (mode == MODE_WARN_I) || (mode == MODE_WARN);

	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			a_d_r <= 1'b0;
			b_d_r <= 1'b0;
		end else begin
			a_d_r <= s.a;
			b_d_r <= s.b;
		end
	end

	// gate is combinational on synchronised inputs: two cycles, far below 20 ms
	assign power_enable_o = both_on;

	// direction of the last transition: set while both are off, cleared while both are on
	logic rising_r;
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			rising_r <= 1'b0;
		end else if (both_off) begin
			rising_r <= 1'b1;
		end else if (both_on) begin
			rising_r <= 1'b0;
		end
	end

	// skew timer in centiseconds while only one input is on
	logic [CNT_W-1:0]  cyc_r;
	logic [TIME_W-1:0] cs_r;
	logic              skew_over;
	always_ff @(posedge clock_i) begin
		if (!nrst_i || !disagree) begin
			cyc_r <= '0;
			cs_r  <= '0;
		end else if (cyc_r == CNT_W'(CS_CYC - 1)) begin
			cyc_r <= '0;
			if (cs_r != '1)
				cs_r <= cs_r + TIME_W'(1);
		end else begin
			cyc_r <= cyc_r + CNT_W'(1);
		end
	end
	// limit only softens mode 05; mode 06 warns on any skew
	assign skew_over = (mode != MODE_WARN_I) || (cs_r >= on_skew_limit_i)
		|| (on_skew_limit_i == TIME_W'(SKEW_LIMIT_CS));

	// warnings, set wins over the both-off clear
	logic wa_on_r, wb_on_r, wa_off_r, wb_off_r;
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			wa_on_r  <= 1'b0;
			wb_on_r  <= 1'b0;
			wa_off_r <= 1'b0;
			wb_off_r <= 1'b0;
		end else begin
			if (warn_mode && disagree && rising_r && skew_over) begin
				if (s.b)
					wa_on_r <= 1'b1;
				else
					wb_on_r <= 1'b1;
			end else if (both_off) begin
				wa_on_r <= 1'b0;
				wb_on_r <= 1'b0;
			end
			if (warn_mode && disagree && !rising_r) begin
				if (s.a)
					wa_off_r <= 1'b1;
				else
					wb_off_r <= 1'b1;
			end else if (both_off) begin
				wa_off_r <= 1'b0;
				wb_off_r <= 1'b0;
			end
		end
	end

	// stop fault, reset input clears only when the cause is gone
	logic e37_r;
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			e37_r <= 1'b0;
		end else if (mode == MODE_LATCH && !both_on) begin
			e37_r <= 1'b1;
		end else if (fault_reset_input_i) begin
			e37_r <= 1'b0;
		end
	end

	// power-off-only faults: cleared by reset alone
	logic e98_r, e99_r;
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			e98_r <= 1'b0;
		end else if (mode == MODE_EXT_INT && disagree) begin
			e98_r <= 1'b1;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			e99_r <= 1'b0;
		end else if (mismatch && (mode == MODE_EXT_INT || mode == MODE_INT_A
			|| mode == MODE_INT_B || mode == MODE_WARN_I)) begin
			e99_r <= 1'b1;
		end
	end

	assign fault_any = e37_r | e98_r | e99_r;
	assign warn_any  = wa_on_r | wb_on_r | wa_off_r | wb_off_r;

	// restart follows held run command without a fresh edge
	always_ff @(posedge clock_i) begin
		if (!nrst_i)
			motor_run_o <= 1'b0;
		else
			motor_run_o <= run_cmd_i & both_on & ~fault_any;
	end

	// display return timer
	view_type         view_r;
	logic [CNT_W-1:0] tcyc_r;
	logic [TIME_W-1:0] tsec_r;
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			view_r <= VIEW_SAFETY;
			tcyc_r <= '0;
			tsec_r <= '0;
		end else begin
			case (view_r)
				VIEW_SAFETY: begin
					tcyc_r <= '0;
					tsec_r <= '0;
					if (key_press_i && display_return_policy_i ==
						2'(POL_RETURN))
						view_r <= VIEW_STANDARD;
				end
				VIEW_STANDARD: begin
					if (key_press_i) begin
						tcyc_r <= '0;
						tsec_r <= '0;
					end else if (tcyc_r == CNT_W'(SEC_CYC - 1)) begin
						tcyc_r <= '0;
						tsec_r <= tsec_r + TIME_W'(1);
					end else begin
						tcyc_r <= tcyc_r + CNT_W'(1);
					end
					if (display_return_policy_i != 2'(POL_RETURN)
						|| tsec_r >= safety_display_return_time_i)
						view_r <= VIEW_SAFETY;
				end
				default: view_r <= VIEW_SAFETY;
			endcase
		end
	end

	// code priority: faults before warnings before torque-off indication
	code_type code_nxt;
	always_comb begin
		code_nxt = CODE_NONE;
		if (e99_r)
			code_nxt = CODE_E99;
		else if (e98_r)
			code_nxt = CODE_E98;
		else if (e37_r)
			code_nxt = CODE_E37;
		else if (wa_on_r)
			code_nxt = CODE_A_LATE_ON;
		else if (wb_on_r)
			code_nxt = CODE_B_LATE_ON;
		else if (wa_off_r)
			code_nxt = CODE_A_LATE_OFF;
		else if (wb_off_r)
			code_nxt = CODE_B_LATE_OFF;
		else if (both_off && mode >= MODE_EXT_INT)
			code_nxt = CODE_STO;
	end

	// output 11 assignment follows the selector edge
	logic diag_m_r, diag_r, diag_d_r;
	logic [7:0] out11_r;
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			diag_m_r <= 1'b0;
			diag_r   <= 1'b0;
			diag_d_r <= 1'b0;
			out11_r  <= 8'h00;
		end else begin
			diag_m_r <= diag_select_switch_i;
			diag_r   <= diag_m_r;
			diag_d_r <= diag_r;
			if (diag_r)
				out11_r <= OUT11_FEEDBACK;
			else if (diag_d_r)
				out11_r <= OUT11_NONE;
			else if (out11_r != OUT11_NONE)
				out11_r <= output11_function_i;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			stop_fault_o              <= 1'b0;
			external_disagree_fault_o <= 1'b0;
			internal_mismatch_fault_o <= 1'b0;
			warn_a_late_on_o          <= 1'b0;
			warn_b_late_on_o          <= 1'b0;
			warn_a_late_off_o         <= 1'b0;
			warn_b_late_off_o         <= 1'b0;
			safety_fault_summary_o    <= 1'b0;
			torque_off_ind_o          <= 1'b0;
			display_code_o            <= 4'h0;
			standard_view_o           <= 1'b0;
			input_status_monitor_o    <= '0;
		end else begin
			stop_fault_o              <= e37_r;
			external_disagree_fault_o <= e98_r;
			internal_mismatch_fault_o <= e99_r;
			warn_a_late_on_o          <= wa_on_r;
			warn_b_late_on_o          <= wb_on_r;
			warn_a_late_off_o         <= wa_off_r;
			warn_b_late_off_o         <= wb_off_r;
			safety_fault_summary_o    <= fault_any | warn_any;
			torque_off_ind_o          <= both_off && mode >= MODE_EXT_INT;
			display_code_o            <= 4'(code_nxt);
			standard_view_o           <= view_r == VIEW_STANDARD;
			input_status_monitor_o    <= digital_inputs_i;
			if (diag_r) begin
				input_status_monitor_o[IN3_BIT] <= s.a;
				input_status_monitor_o[IN4_BIT] <= s.b;
			end
		end
	end

	assign output11_function_o = out11_r;
endmodule : sto_monitor

// *** verif/sto_relay_model.sv ***
// behavioural safety relay driving both stop inputs and the feedback
module sto_relay_model #(
	parameter int unsigned LAG = 8
) (
	// clock
	input  wire logic clock_i,
	// commands from the bench
	input  wire logic cmd_on_i,
	input  wire logic skew_i,
	input  wire logic lag_b_i,
	input  wire logic fb_bad_i,
	// pins
	output logic      a_o,
	output logic      b_o,
	output logic      fb_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       lead_r = 1'b0;
	logic       foll_r = 1'b0;
	logic [7:0] cnt_r  = 8'h00;

	// follower waits LAG cycles only when skew is asked for
	always_ff @(posedge clock_i) begin
		lead_r <= cmd_on_i;
		if (foll_r == cmd_on_i) begin
			cnt_r <= 8'h00;
		end else if (!skew_i || cnt_r == LAG) begin
			foll_r <= cmd_on_i;
			cnt_r  <= 8'h00;
		end else begin
			cnt_r <= cnt_r + 8'h01;
		end
	end

	assign a_o  = lag_b_i ? lead_r : foll_r;
	assign b_o  = lag_b_i ? foll_r : lead_r;
	// feedback reports stop active only with both inputs off
	assign fb_o = (!a_o && !b_o) ^ fb_bad_i;
endmodule // sto_relay_model

// *** verif/sto_checker.sv ***
// port-level assertions for the stop monitor
module sto_checker
	import sto_pkg::*;
(
	// clock, reset and pins
	input wire logic       clock_i,
	input wire logic       nrst_i,
	input wire logic       stop_input_a_i,
	input wire logic       stop_input_b_i,
	input wire logic       diag_select_switch_i,
	input wire logic       fault_reset_input_i,
	input wire logic [2:0] stop_display_mode_i,
	// status
	input wire logic       power_enable_o,
	input wire logic       stop_fault_o,
	input wire logic       external_disagree_fault_o,
	input wire logic       internal_mismatch_fault_o,
	input wire logic       warn_a_late_on_o,
	input wire logic       warn_b_late_on_o,
	input wire logic       warn_a_late_off_o,
	input wire logic       warn_b_late_off_o,
	input wire logic       safety_fault_summary_o,
	input wire logic [7:0] output11_function_o,
	input wire logic [7:0] input_status_monitor_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!nrst_i);

	a_gate_off: assert property (
		(!stop_input_a_i || !stop_input_b_i) |-> ##2 !power_enable_o)
		else $error("power stage still enabled");
	a_gate_on: assert property (
		power_enable_o |-> $past(stop_input_a_i, 2) && $past(stop_input_b_i, 2))
		else $error("power enabled without both inputs");
	a_out11_forced: assert property (
		diag_select_switch_i [*4] |-> ##1 output11_function_o == OUT11_FEEDBACK)
		else $error("output 11 not feedback");
	a_out11_released: assert property (
		output11_function_o == OUT11_FEEDBACK ##1 (!diag_select_switch_i) [*4]
		|=> output11_function_o == OUT11_NONE)
		else $error("output 11 keeps a function");
	a_status_stop_bits: assert property (
		(diag_select_switch_i && stop_input_a_i && stop_input_b_i) [*5]
		|-> input_status_monitor_o[IN3_BIT] && input_status_monitor_o[IN4_BIT])
		else $error("input monitor misses stop inputs");
	a_mode0_quiet: assert property (
		stop_display_mode_i == MODE_NONE && !stop_fault_o |=> !stop_fault_o)
		else $error("stop fault in mode 0");
	a_stop_fault_held: assert property (
		stop_fault_o && !fault_reset_input_i && !$past(fault_reset_input_i)
		|=> stop_fault_o)
		else $error("stop fault cleared without reset input");
	a_ext_sticky: assert property (
		external_disagree_fault_o |=> external_disagree_fault_o)
		else $error("external fault cleared");
	a_int_sticky: assert property (
		internal_mismatch_fault_o |=> internal_mismatch_fault_o)
		else $error("internal fault cleared");
	a_warn_modes: assert property (
		(warn_a_late_on_o || warn_b_late_on_o || warn_a_late_off_o
		|| warn_b_late_off_o) |-> stop_display_mode_i inside {3'h5, 3'h6})
		else $error("warning outside warning modes");
	a_summary_any: assert property (
		safety_fault_summary_o == (stop_fault_o || external_disagree_fault_o
		|| internal_mismatch_fault_o || warn_a_late_on_o || warn_b_late_on_o
		|| warn_a_late_off_o || warn_b_late_off_o))
		else $error("summary disagrees with codes");
endmodule // sto_checker

bind sto_monitor sto_checker chk (.*);

// *** verif/sto_monitor_tb_top.sv ***
// self-checking bench for the stop monitor
module sto_monitor_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import sto_pkg::*;
	localparam int unsigned RESP = 40;
	logic       clock_i = 1'b0;
	logic       nrst_i = 1'b0;
	logic       cmd_on = 1'b0, skew = 1'b0, lag_b = 1'b0, fb_bad = 1'b0;
	logic       diag_select_switch_i = 1'b0, fault_reset_input_i = 1'b0;
	logic       run_cmd_i = 1'b0, key_press_i = 1'b0;
	logic [1:0] display_return_policy_i = 2'h1;
	logic [7:0] on_skew_limit_i = 8'h00;
	logic [2:0] stop_display_mode_i = 3'h0;
	logic [7:0] output11_function_i = 8'h05, digital_inputs_i = 8'h00;
	logic       stop_input_a_i, stop_input_b_i, stop_state_feedback_i;
	logic       power_enable_o, motor_run_o, stop_fault_o;
	logic       external_disagree_fault_o, internal_mismatch_fault_o;
	logic       warn_a_late_on_o, warn_b_late_on_o;
	logic       warn_a_late_off_o, warn_b_late_off_o;
	logic       safety_fault_summary_o, torque_off_ind_o, standard_view_o;
	logic [3:0] display_code_o;
	logic [7:0] output11_function_o, input_status_monitor_o;
	int         failures = 0;
	int         checked = 0;

	sto_monitor #(.RESP_CYC(RESP), .CS_CYC(4), .SEC_CYC(10)) uut (.*,
		.safety_display_return_time_i(8'h02));
	sto_relay_model rly (.clock_i(clock_i), .cmd_on_i(cmd_on), .skew_i(skew),
		.lag_b_i(lag_b), .fb_bad_i(fb_bad), .a_o(stop_input_a_i),
		.b_o(stop_input_b_i), .fb_o(stop_state_feedback_i));

	initial begin
		forever #5 clock_i = ~clock_i;
	end

	task automatic close_out;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// sample a step after the edge so registered outputs have landed
	task automatic cyc(int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask

	task automatic chk(logic [7:0] got, logic [7:0] exp, string m);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("FAIL %0t %s", $time, m);
		end
	endtask

	task automatic wait_pe(logic v);
		for (int i = 0; i < RESP && power_enable_o !== v; i++)
			cyc(1);
		chk(power_enable_o, v, "power enable wait");
		if (power_enable_o !== v)
			close_out();
	endtask

	task automatic rst(logic [2:0] m);
		@(posedge clock_i) nrst_i <= 1'b0;
		stop_display_mode_i <= m;
		cmd_on <= 1'b0;
		fb_bad <= 1'b0;
		cyc(2);
		chk(output11_function_o, 8'h00, "reset output 11");
		@(posedge clock_i) nrst_i <= 1'b1;
		cyc(12);
	endtask

	task automatic set_on(logic v);
		@(posedge clock_i) cmd_on <= v;
		wait_pe(v);
		cyc(5);
	endtask

	task automatic pulse_reset;
		@(posedge clock_i) fault_reset_input_i <= 1'b1;
		@(posedge clock_i) fault_reset_input_i <= 1'b0;
		cyc(4);
	endtask

	task automatic t_gate;
		rst(MODE_NONE);
		run_cmd_i <= 1'b1;
		set_on(1'b1);
		chk(motor_run_o, 1'b1, "no run");
		set_on(1'b0);
		chk(motor_run_o, 1'b0, "runs in stop");
		chk(stop_fault_o, 1'b0, "fault in mode 0");
		set_on(1'b1);
		chk(motor_run_o, 1'b1, "no restart");
		$display("gate test done");
	endtask

	task automatic t_view;
		@(posedge clock_i) key_press_i <= 1'b1;
		@(posedge clock_i) key_press_i <= 1'b0;
		cyc(3);
		chk(standard_view_o, 1'b1, "no standard view");
		cyc(30);
		chk(standard_view_o, 1'b0, "no return");
		display_return_policy_i <= 2'h0;
		@(posedge clock_i) key_press_i <= 1'b1;
		@(posedge clock_i) key_press_i <= 1'b0;
		cyc(3);
		chk(standard_view_o, 1'b0, "view left safety");
		display_return_policy_i <= 2'h1;
		$display("view test done");
	endtask

	task automatic t_diag;
		output11_function_i <= 8'h07;
		digital_inputs_i <= 8'hF0;
		@(posedge clock_i) diag_select_switch_i <= 1'b1;
		cyc(6);
		chk(output11_function_o, OUT11_FEEDBACK, "out11 forced");
		chk(input_status_monitor_o[3:2], 8'h03, "stop bits on");
		set_on(1'b0);
		chk(input_status_monitor_o[3:2], 8'h00, "stop bits off");
		@(posedge clock_i) diag_select_switch_i <= 1'b0;
		cyc(6);
		chk(output11_function_o, OUT11_NONE, "out11 released");
		$display("diag test done");
	endtask

	task automatic t_latch;
		rst(MODE_LATCH);
		chk(stop_fault_o, 1'b1, "no stop fault");
		chk(display_code_o, CODE_E37, "code not stop fault");
		chk(safety_fault_summary_o, 1'b1, "no summary");
		pulse_reset();
		chk(stop_fault_o, 1'b1, "reset with cause");
		set_on(1'b1);
		chk(motor_run_o, 1'b0, "run with fault");
		pulse_reset();
		chk(stop_fault_o, 1'b0, "fault kept");
		chk(motor_run_o, 1'b1, "no restart");
		$display("latch test done");
	endtask

	task automatic t_skew;
		for (int i = 0; i < 2; i++) begin
			rst(MODE_WARN);
			skew <= 1'b1;
			lag_b <= i[0];
			set_on(1'b1);
			chk({warn_a_late_on_o, warn_b_late_on_o}, i ? 1 : 2, "on");
			@(posedge clock_i) cmd_on <= 1'b0;
			cyc(7);
			chk({warn_a_late_off_o, warn_b_late_off_o}, i ? 1 : 2, "off");
			chk(safety_fault_summary_o, 1'b1, "summary");
			cyc(12);
			chk({warn_a_late_on_o, warn_b_late_on_o, warn_a_late_off_o,
				warn_b_late_off_o}, 8'h00, "warnings kept");
		end
		$display("skew test done");
	endtask

	task automatic t_faults;
		// limit far above the relay's lag: only mode 06 may still warn late-on
		on_skew_limit_i <= 8'h10;
		for (int m = 2; m < 7; m++) begin
			rst(m[2:0]);
			chk(torque_off_ind_o, 1'b1, "no torque-off");
			set_on(1'b1);
			chk(internal_mismatch_fault_o, 1'b0, "int early");
			chk(warn_b_late_on_o, m == 6, "on-skew limit");
			chk(external_disagree_fault_o, m == 2, "ext fault");
			@(posedge clock_i) fb_bad <= 1'b1;
			cyc(6);
			chk(internal_mismatch_fault_o, m != 6, "int");
			set_on(1'b0);
			chk(external_disagree_fault_o, m == 2, "ext held");
		end
		$display("fault test done");
	endtask

	initial begin
		t_gate();
		t_view();
		t_diag();
		t_latch();
		t_skew();
		t_faults();
		close_out();
	end
endmodule // sto_monitor_tb_top
